// ---- inc/rsm_regs.svh ----
`ifndef RSM_REGS_SVH
`define RSM_REGS_SVH
// What this block does
// RULE1 - write count gives bytes sent per command, at most 16
// RULE2 - read count gives bytes collected per command, at most 16
// RULE3 - sixteen-byte buffer supplies outgoing bytes and then holds returned bytes
// RULE4 - a write to execute while not busy launches one command with current interface and speed
// RULE5 - send write-count bytes from buffer first, then read read-count bytes into buffer
// RULE6 - completion may signal the host side; here shown only through the status
// RULE7 - execute reads 0 idle-ok, 1 busy, 2 idle-failed
// RULE8 - host writes 1 to execute and polls until idle
// RULE9 - serial clock period follows the speed code of the command register
// RULE10 - SPI waits half a clock period from select to first clock edge
// RULE11 - SPI output data changes after each falling clock edge
// RULE12 - SPI input data is sampled at each rising clock edge
// RULE13 - general outputs may act as SPI chip selects
// RULE14 - command bit 7 picks the port: 0 two-wire, 1 SPI
// RULE15 - speed code 111 means no access and no bytes exchanged
// RULE16 - command, counts and buffer are taken at the launching write
// RULE17 - execute reads busy from the cycle after launch until all bytes are done

// register indices; byte address is four times the index
`define RSM_IDX_BUF0 7'h60
`define RSM_IDX_BUFN 7'h6F
`define RSM_IDX_CMD 7'h70
`define RSM_IDX_WCNT 7'h71
`define RSM_IDX_RCNT 7'h72
`define RSM_IDX_EXEC 7'h74
`define RSM_IDX_GPO 7'h76

`define RSM_MAX_CNT 5'h10
`define RSM_CMD_RST 8'h0E
`define RSM_CNT_RST 8'h00
`define RSM_GPO_RST 3'h0

`define RSM_ST_OK 2'h0
`define RSM_ST_BUSY 2'h1
`define RSM_ST_FAIL 2'h2

`define RSM_CMD_IFACE 7
`define RSM_SPD_NONE 3'h7
`define RSM_SEL_START_ONLY 3'h1

// serial clock periods in ns, link clock period in ns
`define RSM_LINK_NS 32
`define RSM_SPI_8M_NS 125
`define RSM_SPI_4M_NS 250
`define RSM_SPI_2M_NS 500
`define RSM_SPI_1M_NS 1000
`define RSM_SPI_500K_NS 2000
`define RSM_SPI_250K_NS 4000
`define RSM_TW_100K_NS 10000
`define RSM_TW_400K_NS 2500
`define RSM_TW_1M_NS 1000
// half period, rounded up to whole link cycles
`define RSM_HALF(ns) ((((ns) / 2) + `RSM_LINK_NS - 1) / `RSM_LINK_NS)
`endif

// ---- inc/rsm_pkg.sv ----
package rsm_pkg;
    typedef logic [7:0] rsm_byte_t;
    typedef enum logic [2:0] {
        LS_IDLE,
        LS_LEAD,
        LS_LOW,
        LS_HIGH,
        LS_TAIL1,
        LS_TAIL2,
        LS_DONE
    } rsm_lstate_t;
endpackage

// ---- rtl/rsm_master_exec.sv ----
// Decided for this implementation: the APB register port.
`timescale 1ns/1ns
`include "rsm_regs.svh"
module rsm_master_exec
    import rsm_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_clock,
    output logic master_serial_clock,
    output logic master_chip_select_n,
    output logic master_serial_out,
    input wire logic master_serial_in,
    output logic [2:0] general_out,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);

////////////////////////////////////////////////////////////////////////
function automatic logic is_buf(input logic [6:0] i);
    return i >= `RSM_IDX_BUF0 && i <= `RSM_IDX_BUFN;
endfunction

function automatic logic [4:0] clamp16(input rsm_byte_t v);
    return (v > 8'(`RSM_MAX_CNT)) ? `RSM_MAX_CNT : v[4:0];
endfunction

function automatic logic [7:0] half_of(input logic spi, input logic [2:0] spd);
    logic [7:0] h;
    h = 8'(`RSM_HALF(`RSM_SPI_8M_NS));
    if (spi) begin
        unique case (spd)
            3'h2: h = 8'(`RSM_HALF(`RSM_SPI_4M_NS));
            3'h3: h = 8'(`RSM_HALF(`RSM_SPI_2M_NS));
            3'h4: h = 8'(`RSM_HALF(`RSM_SPI_1M_NS));
            3'h5: h = 8'(`RSM_HALF(`RSM_SPI_500K_NS));
            3'h6: h = 8'(`RSM_HALF(`RSM_SPI_250K_NS));
            default: h = 8'(`RSM_HALF(`RSM_SPI_8M_NS));
        endcase
    end else begin
        unique case (spd)
            3'h2: h = 8'(`RSM_HALF(`RSM_TW_400K_NS));
            3'h3: h = 8'(`RSM_HALF(`RSM_TW_1M_NS));
            default: h = 8'(`RSM_HALF(`RSM_TW_100K_NS));
        endcase
    end
    return h;
endfunction

// sda drive (pull low) for two-wire bit b of a byte
function automatic logic tw_drive(input logic [3:0] b, input logic rd, input logic last, input logic d);
    return (b == 4'h8) ? (rd && !last) : (!rd && !d);
endfunction

////////////////////////////////////////////////////////////////////////
// register side, on clock
rsm_byte_t cmd, wcnt, rcnt, mem [16];
logic [2:0] gpo;
logic [1:0] status;
logic start_tgl, done_seen;
rsm_byte_t snap_cmd, snap_tx [16];
logic [4:0] snap_w, snap_r;
logic [2:0] done_sync;
logic done_f;

rsm_byte_t next_cmd, next_wcnt, next_rcnt, next_mem [16];
logic [2:0] next_gpo;
logic [1:0] next_status;
logic next_start_tgl, next_done_seen, next_done_f;
rsm_byte_t next_snap_cmd, next_snap_tx [16];
logic [4:0] next_snap_w, next_snap_r;
logic [31:0] next_prdata;
logic next_pready, next_pslverr;

// link side results, stable once the done toggle is seen
rsm_byte_t l_rx [16];
logic l_fail, l_done_tgl;

logic [6:0] idx;
logic mapped, wr_en, done_ev;
rsm_byte_t rd_byte;

assign idx = paddr[8:2];
assign done_ev = done_f != done_seen;

always_comb begin
    mapped = paddr[11:9] == 3'h0 && paddr[1:0] == 2'h0 &&
             (is_buf(idx) || idx == `RSM_IDX_CMD || idx == `RSM_IDX_WCNT ||
              idx == `RSM_IDX_RCNT || idx == `RSM_IDX_EXEC || idx == `RSM_IDX_GPO);
    wr_en = psel && penable && pready && pwrite && mapped;
    rd_byte = 8'h00;
    if (is_buf(idx))
        rd_byte = mem[idx[3:0]]; // RULE3
    else if (idx == `RSM_IDX_CMD)
        rd_byte = cmd;
    else if (idx == `RSM_IDX_WCNT)
        rd_byte = wcnt;
    else if (idx == `RSM_IDX_RCNT)
        rd_byte = rcnt;
    else if (idx == `RSM_IDX_EXEC)
        rd_byte = {6'h00, status}; // RULE7
    else if (idx == `RSM_IDX_GPO)
        rd_byte = {5'h00, gpo};
end

always_comb begin
    next_cmd = cmd;
    next_wcnt = wcnt;
    next_rcnt = rcnt;
    next_mem = mem;
    next_gpo = gpo;
    next_status = status;
    next_start_tgl = start_tgl;
    next_done_seen = done_seen;
    next_snap_cmd = snap_cmd;
    next_snap_tx = snap_tx;
    next_snap_w = snap_w;
    next_snap_r = snap_r;
    // zero wait states: answer is prepared in the setup cycle
    next_pready = psel && !penable;
    next_pslverr = psel && !penable && !mapped;
    next_prdata = (psel && !penable && !pwrite && mapped) ? {24'h000000, rd_byte} : 32'h00000000;
    next_done_f = (done_sync[1] == done_sync[2]) ? done_sync[2] : done_f;
    if (done_ev) begin
        next_done_seen = done_f;
        next_status = l_fail ? `RSM_ST_FAIL : `RSM_ST_OK; // RULE6 RULE7 RULE17
        for (int i = 0; i < 16; i++) begin
            if (5'(i) < snap_r)
                next_mem[i] = l_rx[i]; // RULE5
        end
    end
    if (wr_en) begin
        if (is_buf(idx))
            next_mem[idx[3:0]] = pwdata[7:0];
        else if (idx == `RSM_IDX_CMD)
            next_cmd = pwdata[7:0];
        else if (idx == `RSM_IDX_WCNT)
            next_wcnt = pwdata[7:0]; // RULE1
        else if (idx == `RSM_IDX_RCNT)
            next_rcnt = pwdata[7:0]; // RULE2
        else if (idx == `RSM_IDX_GPO)
            next_gpo = pwdata[2:0];
        else if (idx == `RSM_IDX_EXEC && status != `RSM_ST_BUSY) begin
            // snapshot keeps the link side stable while software edits the registers
            next_snap_cmd = cmd; // RULE16
            next_snap_tx = mem;
            next_snap_w = clamp16(wcnt); // RULE1
            next_snap_r = clamp16(rcnt); // RULE2
            next_start_tgl = !start_tgl; // RULE4
            next_status = `RSM_ST_BUSY; // RULE17
        end
    end
end

always_ff @(posedge clock) begin
    done_sync <= {done_sync[1:0], l_done_tgl};
    if (!resetn) begin
        cmd <= `RSM_CMD_RST;
        wcnt <= `RSM_CNT_RST;
        rcnt <= `RSM_CNT_RST;
        for (int i = 0; i < 16; i++) begin
            mem[i] <= 8'h00;
            snap_tx[i] <= 8'h00;
        end
        gpo <= `RSM_GPO_RST;
        status <= `RSM_ST_OK;
        start_tgl <= 1'b0;
        done_seen <= 1'b0;
        done_f <= 1'b0;
        snap_cmd <= `RSM_CMD_RST;
        snap_w <= 5'h00;
        snap_r <= 5'h00;
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        cmd <= next_cmd;
        wcnt <= next_wcnt;
        rcnt <= next_rcnt;
        mem <= next_mem;
        snap_tx <= next_snap_tx;
        gpo <= next_gpo;
        status <= next_status;
        start_tgl <= next_start_tgl;
        done_seen <= next_done_seen;
        done_f <= next_done_f;
        snap_cmd <= next_snap_cmd;
        snap_w <= next_snap_w;
        snap_r <= next_snap_r;
        prdata <= next_prdata;
        pready <= next_pready;
        pslverr <= next_pslverr;
    end
end

launch_busy_a: assert property (@(posedge clock) disable iff (!resetn)
    wr_en && idx == `RSM_IDX_EXEC && status != `RSM_ST_BUSY |=> status == `RSM_ST_BUSY) // RULE17
    else $error("launch did not show busy");
busy_hold_a: assert property (@(posedge clock) disable iff (!resetn)
    status == `RSM_ST_BUSY && !done_ev |=> status == `RSM_ST_BUSY) // RULE7
    else $error("busy dropped before completion");
status_code_a: assert property (@(posedge clock) disable iff (!resetn)
    status != 2'h3) // RULE7
    else $error("illegal status code");
snap_stable_a: assert property (@(posedge clock) disable iff (!resetn)
    status == `RSM_ST_BUSY && $past(status) == `RSM_ST_BUSY |-> $stable(snap_cmd) && $stable(snap_w)) // RULE16
    else $error("snapshot changed during command");
count_limit_a: assert property (@(posedge clock) disable iff (!resetn)
    snap_w <= `RSM_MAX_CNT && snap_r <= `RSM_MAX_CNT) // RULE1
    else $error("count above sixteen");
apb_answer_a: assert property (@(posedge clock) disable iff (!resetn)
    psel && !penable |=> pready ##1 !pready)
    else $error("apb answer timing");

////////////////////////////////////////////////////////////////////////
// link side, on link_clock
logic [2:0] lrst;
logic link_ok;
logic [6:0] pin_raw, s1, s2, s3, filt;
logic f_miso, f_scl, f_sda, f_start, start_seen;
logic [2:0] f_gpo;

assign link_ok = lrst[1] && lrst[2];
assign pin_raw = {start_tgl, gpo, sda_in, scl_in, master_serial_in};
assign {f_start, f_gpo, f_sda, f_scl, f_miso} = filt;

always_ff @(posedge link_clock)
    lrst <= {lrst[1:0], resetn};

// three flops; a level counts once the second and third agree
for (genvar g = 0; g < 7; g++) begin : g_sync
    always_ff @(posedge link_clock) begin
        s1[g] <= pin_raw[g];
        s2[g] <= s1[g];
        s3[g] <= s2[g];
        if (!link_ok)
            filt[g] <= 1'b0;
        else if (s2[g] == s3[g])
            filt[g] <= s3[g];
    end
end

rsm_lstate_t st, next_st;
logic [7:0] hcnt, next_hcnt, half;
logic [5:0] byte_idx, next_byte, total;
logic [3:0] bit_idx, next_bit;
rsm_byte_t sh, next_sh, sh_in;
rsm_byte_t next_rx [16];
logic [3:0] rise_q, next_rise_q;
rsm_byte_t rx_sh, next_rx_sh;
logic [7:0] rx_bits, next_rx_bits;
logic next_fail, next_done_tgl, next_start_seen, csa, next_csa;
logic next_sck, next_cs_n, next_mosi, next_scl_oe, next_sda_oe;
logic [2:0] next_gpo_out;
logic spi, illegal, start_ev, phase_end, in_bit, rd, last_bit, nrd, nlast;
logic [2:0] spd, ssel;

assign spi = snap_cmd[`RSM_CMD_IFACE]; // RULE14
assign spd = snap_cmd[3:1];
assign ssel = snap_cmd[6:4];
assign half = half_of(spi, spd); // RULE9
assign illegal = !spi && (spd == 3'h0 || (spd >= 3'h4 && spd != `RSM_SPD_NONE));
assign total = {1'b0, snap_w} + {1'b0, snap_r};
assign start_ev = f_start != start_seen;
assign phase_end = hcnt == 8'h01;
assign rd = byte_idx >= {1'b0, snap_w};

function automatic rsm_byte_t byte_at(input logic [5:0] b, input logic [4:0] w, input logic s,
                                      input rsm_byte_t tx [16]);
    return (b < {1'b0, w}) ? tx[b[3:0]] : (s ? 8'h00 : 8'hFF);
endfunction

always_comb begin
    next_st = st;
    next_hcnt = phase_end ? half : hcnt - 8'h01;
    next_byte = byte_idx;
    next_bit = bit_idx;
    next_sh = sh;
    next_rx = l_rx;
    next_fail = l_fail;
    next_done_tgl = l_done_tgl;
    next_start_seen = start_seen;
    next_csa = csa;
    next_sck = master_serial_clock;
    next_mosi = master_serial_out;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    in_bit = spi ? f_miso : f_sda;
    sh_in = {sh[6:0], in_bit};
    last_bit = bit_idx == (spi ? 4'h7 : 4'h8);
    nrd = 1'b0;
    nlast = 1'b0;
    // the input synchroniser lags four link edges, so the bit standing at a rising
    // clock edge is taken four edges later; at the fastest rate that is past the fall
    next_rx_sh = rx_sh;
    next_rx_bits = rx_bits;
    if (rise_q[3]) begin
        next_rx_sh = {rx_sh[6:0], f_miso}; // RULE12
        next_rx_bits = rx_bits + 8'h01;
        if (rx_bits[2:0] == 3'h7 && rx_bits[7:3] >= snap_w)
            next_rx[4'(rx_bits[7:3] - snap_w)] = {rx_sh[6:0], f_miso}; // RULE5
    end
    unique case (st)
        LS_IDLE: begin
            next_hcnt = half;
            if (start_ev) begin
                next_start_seen = f_start;
                next_fail = 1'b0;
                next_byte = 6'h00;
                next_bit = 4'h0;
                next_rx_bits = 8'h00;
                next_sh = byte_at(6'h00, snap_w, spi, snap_tx);
                if (spd == `RSM_SPD_NONE) begin
                    next_st = LS_DONE; // RULE15
                end else if (illegal) begin
                    next_fail = 1'b1;
                    next_st = LS_DONE;
                end else begin
                    next_st = LS_LEAD;
                    next_csa = spi;
                    next_mosi = spi ? next_sh[7] : 1'b0;
                    next_sda_oe = !spi; // start condition
                end
            end
        end
        LS_LEAD: if (phase_end) begin // RULE10
            if (total == 6'h00) begin
                next_st = LS_TAIL1;
                next_scl_oe = !spi;
            end else if (spi) begin
                next_st = LS_HIGH;
                next_sck = 1'b1;
            end else begin
                next_st = LS_LOW;
                next_scl_oe = 1'b1;
                next_sda_oe = tw_drive(4'h0, rd, total == 6'h01, sh[7]);
            end
        end
        LS_LOW: if (phase_end) begin
            next_st = LS_HIGH;
            next_sck = spi;
            next_scl_oe = 1'b0;
        end
        LS_HIGH: begin
            // a slave holding the clock low stretches the high phase
            if (!spi && !f_scl)
                next_hcnt = hcnt;
            else if (phase_end) begin
                if (!(!spi && bit_idx == 4'h8))
                    next_sh = sh_in; // RULE12
                next_st = LS_LOW;
                next_bit = bit_idx + 4'h1;
                if (last_bit) begin
                    if (rd && !spi)
                        next_rx[4'(byte_idx - {1'b0, snap_w})] = sh; // RULE5
                    next_byte = byte_idx + 6'h01;
                    next_bit = 4'h0;
                    next_sh = byte_at(next_byte, snap_w, spi, snap_tx);
                    if (!spi && !rd && in_bit) begin
                        next_fail = 1'b1;
                        next_st = LS_TAIL1;
                    end
                    if (next_byte == total)
                        next_st = LS_TAIL1;
                end
                nrd = next_byte >= {1'b0, snap_w};
                nlast = next_byte + 6'h01 == total;
                next_sck = 1'b0;
                next_scl_oe = !spi;
                if (next_st == LS_LOW) begin
                    next_mosi = spi ? next_sh[7] : 1'b0; // RULE11
                    next_sda_oe = !spi && tw_drive(next_bit, nrd, nlast, next_sh[7]);
                end else
                    next_sda_oe = !spi && ssel != `RSM_SEL_START_ONLY;
            end
        end
        LS_TAIL1: if (phase_end) begin
            next_st = spi ? LS_DONE : LS_TAIL2;
            next_csa = 1'b0;
            next_scl_oe = 1'b0;
        end
        LS_TAIL2: if (phase_end) begin
            next_st = LS_DONE;
            next_sda_oe = 1'b0; // stop condition
        end
        LS_DONE: begin
            next_st = LS_IDLE;
            next_done_tgl = !l_done_tgl;
        end
    endcase
    next_rise_q = {rise_q[2:0], spi && next_sck && !master_serial_clock};
    next_cs_n = !(next_csa && spi && ssel[1:0] == 2'h0);
    for (int n = 0; n < 3; n++) begin
        if (spi && ssel[1:0] == 2'(n + 1))
            next_gpo_out[n] = ssel[2] ? next_csa : !next_csa; // RULE13
        else
            next_gpo_out[n] = f_gpo[n];
    end
end

always_ff @(posedge link_clock) begin
    if (!link_ok) begin
        st <= LS_IDLE;
        hcnt <= 8'h01;
        byte_idx <= 6'h00;
        bit_idx <= 4'h0;
        sh <= 8'h00;
        rise_q <= 4'h0;
        rx_sh <= 8'h00;
        rx_bits <= 8'h00;
        for (int i = 0; i < 16; i++)
            l_rx[i] <= 8'h00;
        l_fail <= 1'b0;
        l_done_tgl <= 1'b0;
        start_seen <= 1'b0;
        csa <= 1'b0;
        master_serial_clock <= 1'b0;
        master_chip_select_n <= 1'b1;
        master_serial_out <= 1'b0;
        general_out <= 3'h0;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
    end else begin
        st <= next_st;
        hcnt <= next_hcnt;
        byte_idx <= next_byte;
        bit_idx <= next_bit;
        sh <= next_sh;
        rise_q <= next_rise_q;
        rx_sh <= next_rx_sh;
        rx_bits <= next_rx_bits;
        l_rx <= next_rx;
        l_fail <= next_fail;
        l_done_tgl <= next_done_tgl;
        start_seen <= next_start_seen;
        csa <= next_csa;
        master_serial_clock <= next_sck;
        master_chip_select_n <= next_cs_n;
        master_serial_out <= next_mosi;
        general_out <= next_gpo_out;
        scl_oe <= next_scl_oe;
        sda_oe <= next_sda_oe;
    end
end

// open-drain lines only ever pull low
always_ff @(posedge link_clock) begin
    scl_out <= 1'b0;
    sda_out <= 1'b0;
end

sequence clk_low_hold;
    !master_serial_clock [*2];
endsequence
sequence clk_high_hold;
    master_serial_clock [*2];
endsequence

lead_delay_a: assert property (@(posedge link_clock) disable iff (!link_ok)
    $rose(csa) |-> clk_low_hold) // RULE10
    else $error("clock too soon after select");
high_phase_a: assert property (@(posedge link_clock) disable iff (!link_ok)
    spi && $rose(master_serial_clock) |-> clk_high_hold) // RULE9
    else $error("serial clock high phase too short");
mosi_edge_a: assert property (@(posedge link_clock) disable iff (!link_ok)
    spi && csa && $past(csa) && $changed(master_serial_out) |-> $fell(master_serial_clock)) // RULE11
    else $error("serial out changed off falling edge");
no_access_a: assert property (@(posedge link_clock) disable iff (!link_ok)
    st == LS_IDLE && start_ev && spd == `RSM_SPD_NONE |=> st == LS_DONE && !csa ##1 st == LS_IDLE) // RULE15
    else $error("no-access code touched the port");
endmodule

// ---- tb/rsm_spi_peer.sv ----
`timescale 1ns/1ns
module rsm_spi_peer (
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic [31:0] pattern,
    output logic miso,
    output logic [31:0] got,
    output int rises,
    output time lead_ns,
    output time high_ns
);
    int idx = 31;
    int nfr = 0;
    time t_sel = 0;
    time t_rise = 0;
    initial begin
        miso = 1'b0;
        got = '0;
        rises = 0;
        lead_ns = 0;
        high_ns = 0;
    end
    ////////////////////////////////////////////////////////////////
    // frame start: first bit is presented before the first clock
    always @(negedge cs_n) begin
        t_sel = $time;
        nfr = 0;
        got = '0;
        miso = pattern[31];
        idx = 30;
    end
    // deselected: never leave the last bit standing
    always @(posedge cs_n) begin
        miso = ~miso;
    end
    always @(posedge sck) begin
        if (nfr == 0) begin
            lead_ns = $time - t_sel;
        end
        nfr++;
        rises++;
        t_rise = $time;
        got = {got[30:0], mosi};
    end
    // reply bit moves only after the falling edge, so it is steady at the rising one
    always @(negedge sck) begin
        high_ns = $time - t_rise;
        if (!cs_n && idx >= 0) begin
            miso = pattern[idx];
            idx--;
        end
    end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
`include "rsm_regs.svh"
module testbench;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic link_clock = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, sck, cs_n, mosi, miso, scl_oe, sda_oe, last_err;
    logic [2:0] general_out;
    logic [31:0] got, r;
    int rises, fails = 0, n_tests = 0, n_scl = 0, n0, i;
    time lead_ns, high_ns;
    // open-drain lines with pull-ups; no two-wire slave answers, so every byte is unacknowledged
    wire scl_in = ~scl_oe;
    wire sda_in = ~sda_oe;

    always #2 clock = ~clock;
    initial begin
        #3;
        forever #16 link_clock = ~link_clock;
    end
    always @(posedge scl_oe) n_scl++;

    rsm_master_exec dut_u (.clock(clock), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_clock(link_clock), .master_serial_clock(sck), .master_chip_select_n(cs_n),
        .master_serial_out(mosi), .master_serial_in(miso), .general_out(general_out),
        .scl_in(scl_in), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(), .sda_oe(sda_oe));
    rsm_spi_peer peer_u (.sck(sck), .cs_n(cs_n), .mosi(mosi), .pattern(32'h0F0F5AC3), .miso(miso),
        .got(got), .rises(rises), .lead_ns(lead_ns), .high_ns(high_ns));

    ////////////////////////////////////////////////////////////////
    task complete_run;
        $display("mismatches %0d comparisons %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task check(input logic [31:0] val, input logic [31:0] exp);
        n_tests++;
        if (val !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, val, exp);
        end
    endtask
    // one APB transfer; request held until pready is seen at a rising edge
    task xfer(input logic w, input logic [6:0] idx, input logic [31:0] d, output logic [31:0] rd);
        int k;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {3'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (k = 0; k < 8; k++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        if (k == 8) begin
            fails++;
            complete_run;
        end
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [6:0] idx, input logic [31:0] d);
        xfer(1'b1, idx, d, r);
    endtask
    task rd_chk(input logic [6:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 32'h0, r);
        check(r, exp);
    endtask
    task launch_poll(input logic [1:0] exp_st);
        int k;
        wr(`RSM_IDX_EXEC, 32'h01);
        rd_chk(`RSM_IDX_EXEC, {30'h0, `RSM_ST_BUSY});
        for (k = 0; k < 20000; k++) begin
            xfer(1'b0, `RSM_IDX_EXEC, 32'h0, r);
            if (r !== 32'h1) break;
        end
        if (k == 20000) begin
            fails++;
            complete_run;
        end
        check(r, {30'h0, exp_st});
    endtask
    // two bytes out, two bytes back in one select
    task spi_run(input logic [7:0] cmd, input logic [31:0] half_ns);
        wr(`RSM_IDX_CMD, {24'h0, cmd});
        wr(`RSM_IDX_WCNT, 32'h2);
        wr(`RSM_IDX_RCNT, 32'h2);
        wr(`RSM_IDX_BUF0, 32'hA5);
        wr(`RSM_IDX_BUF0 + 7'h1, 32'h3C);
        launch_poll(`RSM_ST_OK);
        check(got, 32'hA53C0000);
        rd_chk(`RSM_IDX_BUF0, 32'h5A);
        rd_chk(`RSM_IDX_BUF0 + 7'h1, 32'hC3);
        check(32'(lead_ns), half_ns);
        check(32'(high_ns), half_ns);
    endtask

    ////////////////////////////////////////////////////////////////
    // eight cycles span a link edge, which starts the link-side reset; the idle wait lets it finish
    initial begin
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        repeat (80) @(posedge clock);
        rd_chk(`RSM_IDX_CMD, 32'h0E);
        rd_chk(`RSM_IDX_WCNT, 32'h0);
        rd_chk(`RSM_IDX_RCNT, 32'h0);
        rd_chk(`RSM_IDX_EXEC, 32'h0);
        rd_chk(7'h7F, 32'h0);
        check({31'h0, last_err}, 32'h1);
        wr(`RSM_IDX_GPO, 32'h5);
        for (i = 0; i < 100 && general_out !== 3'h5; i++) @(posedge clock);
        check({29'h0, general_out}, 32'h5);
        spi_run(8'h80, 32'd64);
        spi_run(8'h84, 32'd128);
        n0 = rises;
        wr(`RSM_IDX_CMD, 32'h8E);
        launch_poll(`RSM_ST_OK);
        check(rises, n0);
        wr(`RSM_IDX_CMD, 32'h00);
        launch_poll(`RSM_ST_FAIL);
        check(n_scl, 32'h0);
        wr(`RSM_IDX_CMD, 32'h06);
        wr(`RSM_IDX_WCNT, 32'h1);
        launch_poll(`RSM_ST_FAIL);
        check({31'h0, n_scl > 0}, 32'h1);
        check(rises, n0);
        complete_run;
    end
endmodule
